// ### src/wpil_params.svh
// Constants for the wake-up port interrupt logic.
// Assumes inclusion by bare name from the package and modules.
`ifndef WPIL_PARAMS_SVH
`define WPIL_PARAMS_SVH

`define WPIL_CLK_HZ 10000000
`define WPIL_TIMEOUT_MS 7
// Bus grant timeout, longest time rounds down
`define WPIL_TIMEOUT_CYC ((`WPIL_CLK_HZ / 1000) * `WPIL_TIMEOUT_MS)
`define WPIL_PORT_DEFAULT 16'h0100
`define WPIL_HOST_LEVEL_DEFAULT 3'h5
`define WPIL_APB_CTRL 12'h000
`define WPIL_APB_STATUS 12'h004
`define WPIL_APB_MASK 12'h008
`define WPIL_APB_IOSTAT 12'h00C
`define WPIL_APB_HOSTIRQ 12'h010
`define WPIL_NSRC 8
`define WPIL_BIT_WAKE 0
`define WPIL_BIT_TIMER 1
`define WPIL_BIT_DMA 2
`define WPIL_BIT_IOSYS 3
`define WPIL_BIT_NMI 4
`define WPIL_BIT_ATTN 5
`define WPIL_BIT_TMO 6
`define WPIL_BIT_PFAIL 7
`define WPIL_CTRL_RESUME 0
`define WPIL_CTRL_HOSTREQ 1
`define WPIL_NIO 4
`define WPIL_IO_ECC 3

`endif

// ### src/wpil_pkg.sv
// Types of the wake-up port interrupt logic.
// Assumes the params header is on the include path.
`include "wpil_params.svh"
package wpil_pkg;
   typedef enum logic [1:0] {wpil_run, wpil_halt} wpil_run_t;
   typedef logic [15:0] wpil_addr_t;
endpackage

// ### src/wpil_io_if.sv
// Interface carrying I/O system requests to the main module.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface wpil_io_if;
   logic [3:0] req;
   logic [3:0] pend;
   logic [3:0] ack;
   modport src (output pend, input req, input ack);
   modport dst (input pend, output req, output ack);
endinterface

// ### src/wpil_iosys_irq.sv
// I/O system interrupt unit: four sticky request inputs.
// Assumes synchronous level inputs; acks are one-cycle pulses.
`timescale 1ns/1ps
`include "wpil_params.svh"
module wpil_iosys_irq
   import wpil_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   wpil_io_if.src io
);
   logic [`WPIL_NIO-1:0] pend;
   logic [`WPIL_NIO-1:0] next_pend;
   genvar g;
   generate
      for (g = 0; g < `WPIL_NIO; g = g + 1) begin : gen_src
         // Set wins over ack so no request is lost
         always_comb begin
            next_pend[g] = (pend[g] & ~io.ack[g]) | io.req[g];
         end
      end
   endgenerate
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pend <= '0;
      end else begin
         pend <= next_pend;
      end
   end
   assign io.pend = pend;
endmodule

// ### src/wpil_top.sv
// Wake-up port and on-board interrupt logic with APB register access.
// Assumes host bus strobes and sources are synchronous to clk_i.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "wpil_params.svh"
module wpil_top
   import wpil_pkg::*;
#(
   parameter int TIMEOUT_CYC = `WPIL_TIMEOUT_CYC
)
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [15:0] port_strap_i,
   input wire logic io_space_width_strap_i,
   input wire logic pfail_enable_i,
   input wire logic host_io_write_i,
   input wire logic [15:0] host_io_addr_i,
   input wire logic [7:0] host_io_data_i,
   input wire logic [2:0] host_level_i,
   input wire logic timer_irq_i,
   input wire logic dma_irq_i,
   input wire logic error_nmi_i,
   input wire logic [2:0] periph_irq_i,
   input wire logic ecc_error_i,
   input wire logic bus_req_i,
   input wire logic bus_grant_i,
   input wire logic power_fail_i,
   input wire logic wake_ack_i,
   input wire logic [3:0] io_ack_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic cpu_irq_o,
   output logic cpu_nmi_o,
   output logic wake_pending_o,
   output logic [3:0] io_pending_o,
   output logic io_halt_o,
   output logic cpu_halt_o,
   output logic error_post_o,
   output logic [7:0] host_irq_n_o,
   output logic [7:0] wake_data_o
);
   ////////////////////////////////////////////////////////////////////////
   // State
   wpil_io_if io_bus();
   wpil_run_t run;
   wpil_run_t next_run;
   logic wake_pend, next_wake_pend;
   logic [7:0] wake_data, next_wake_data;
   logic [`WPIL_NSRC-1:0] status, next_status;
   logic [`WPIL_NSRC-1:0] mask, next_mask;
   logic host_req, next_host_req;
   logic [2:0] level, next_level;
   logic level_loaded, next_level_loaded;
   logic cpu_halt, next_cpu_halt;
   logic err_post, next_err_post;
   logic [22:0] tmo_cnt, next_tmo_cnt;
   logic [31:0] rdata, next_rdata;
   logic slverr, next_slverr;
   logic nmi_lat, next_nmi_lat;
   logic pfail_q, next_pfail_q;
   ////////////////////////////////////////////////////////////////////////
   // Decode
   wpil_addr_t port_addr;
   logic port_hit, wake_wr, attn_wr, tmo_hit, pfail_rise, nmi_evt, resume;
   logic apb_wr, apb_rd;
   logic [`WPIL_NSRC-1:0] events;
   assign port_addr = port_strap_i;
   // Narrow space ignores upper eight bits of both host address and port strap
   always_comb begin
      if (io_space_width_strap_i) begin
         port_hit = (host_io_addr_i == port_addr);
      end else begin
         port_hit = (host_io_addr_i[7:0] == port_addr[7:0]);
      end
   end
   assign wake_wr = host_io_write_i & port_hit;
   // Channel 0 attention: data zero written to the port
   assign attn_wr = wake_wr & (host_io_data_i == 8'h00);
   assign tmo_hit = (tmo_cnt == 23'(TIMEOUT_CYC - 1)) & bus_req_i & ~bus_grant_i;
   assign pfail_rise = power_fail_i & ~pfail_q & pfail_enable_i;
   assign nmi_evt = attn_wr | tmo_hit | pfail_rise | error_nmi_i;
   assign resume = wake_wr & ~attn_wr;
   assign apb_wr = psel & penable & pwrite;
   // Read decoded in setup so data stands at the access edge
   assign apb_rd = psel & ~penable & ~pwrite;
   assign io_bus.req = {ecc_error_i, periph_irq_i};
   assign io_bus.ack = io_ack_i;
   always_comb begin
      events = '0;
      events[`WPIL_BIT_WAKE] = wake_wr;
      events[`WPIL_BIT_TIMER] = timer_irq_i;
      events[`WPIL_BIT_DMA] = dma_irq_i;
      events[`WPIL_BIT_IOSYS] = |io_bus.pend;
      events[`WPIL_BIT_NMI] = error_nmi_i;
      events[`WPIL_BIT_ATTN] = attn_wr;
      events[`WPIL_BIT_TMO] = tmo_hit;
      events[`WPIL_BIT_PFAIL] = pfail_rise;
   end
   wpil_iosys_irq u_iosys (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .io(io_bus)
   );
   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_wake_pend = (wake_pend & ~wake_ack_i) | wake_wr;
      next_wake_data = wake_wr ? host_io_data_i : wake_data;
      next_pfail_q = power_fail_i;
      next_nmi_lat = nmi_evt;
      next_tmo_cnt = (bus_req_i & ~bus_grant_i & ~tmo_hit) ? tmo_cnt + 23'h000001 : 23'h000000;
      next_run = run;
      next_cpu_halt = cpu_halt;
      next_err_post = err_post;
      if (resume) begin
         next_run = wpil_run;
         next_cpu_halt = 1'b0;
         next_err_post = 1'b0;
      end
      if (nmi_evt) begin
         next_run = wpil_halt;
      end
      if (tmo_hit) begin
         next_err_post = 1'b1;
      end
      if (pfail_rise) begin
         next_cpu_halt = 1'b1;
      end
      next_mask = mask;
      next_host_req = host_req;
      next_level = level;
      next_level_loaded = 1'b1;
      if (!level_loaded) begin
         next_level = host_level_i;
      end
      next_status = status;
      next_rdata = rdata;
      next_slverr = 1'b0;
      if (apb_wr) begin
         case (paddr)
            `WPIL_APB_STATUS: next_status = status & ~pwdata[`WPIL_NSRC-1:0];
            `WPIL_APB_MASK: next_mask = pwdata[`WPIL_NSRC-1:0];
            `WPIL_APB_CTRL: begin
               next_host_req = pwdata[`WPIL_CTRL_HOSTREQ];
               if (pwdata[`WPIL_CTRL_RESUME] && !nmi_evt) begin
                  next_run = wpil_run;
                  next_cpu_halt = 1'b0;
               end
            end
            `WPIL_APB_HOSTIRQ: next_level = pwdata[2:0];
            default: next_mask = mask;
         endcase
      end
      // Error flag decided in setup so it stands through the access cycle
      if (psel && !penable) begin
         case (paddr)
            `WPIL_APB_CTRL: next_slverr = 1'b0;
            `WPIL_APB_STATUS: next_slverr = 1'b0;
            `WPIL_APB_MASK: next_slverr = 1'b0;
            `WPIL_APB_HOSTIRQ: next_slverr = 1'b0;
            `WPIL_APB_IOSTAT: next_slverr = pwrite;
            default: next_slverr = 1'b1;
         endcase
      end
      // Set wins over the write-one clear
      next_status = next_status | events;
      if (apb_rd) begin
         case (paddr)
            `WPIL_APB_CTRL: next_rdata = {30'h00000000, host_req, run == wpil_halt};
            `WPIL_APB_STATUS: next_rdata = {24'h000000, status};
            `WPIL_APB_MASK: next_rdata = {24'h000000, mask};
            `WPIL_APB_IOSTAT: next_rdata = {20'h00000, wake_data, io_bus.pend};
            `WPIL_APB_HOSTIRQ: next_rdata = {29'h00000000, level};
            default: begin
               next_rdata = 32'h00000000;
               next_slverr = 1'b1;
            end
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         run <= wpil_run;
         wake_pend <= 1'b0;
         wake_data <= 8'h00;
         status <= '0;
         mask <= '0;
         host_req <= 1'b0;
         level <= `WPIL_HOST_LEVEL_DEFAULT;
         level_loaded <= 1'b0;
         cpu_halt <= 1'b0;
         err_post <= 1'b0;
         tmo_cnt <= 23'h000000;
         rdata <= 32'h00000000;
         slverr <= 1'b0;
         nmi_lat <= 1'b0;
         pfail_q <= 1'b0;
      end else begin
         run <= next_run;
         wake_pend <= next_wake_pend;
         wake_data <= next_wake_data;
         status <= next_status;
         mask <= next_mask;
         host_req <= next_host_req;
         level <= next_level;
         level_loaded <= next_level_loaded;
         cpu_halt <= next_cpu_halt;
         err_post <= next_err_post;
         tmo_cnt <= next_tmo_cnt;
         rdata <= next_rdata;
         slverr <= next_slverr;
         nmi_lat <= next_nmi_lat;
         pfail_q <= next_pfail_q;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Outputs
   // Access phase lasts one cycle; read data registered at setup
   assign pready = 1'b1;
   assign pslverr = psel & penable & slverr;
   assign prdata = rdata;
   assign cpu_irq_o = |(status & mask);
   assign cpu_nmi_o = nmi_lat;
   assign wake_pending_o = wake_pend;
   assign io_pending_o = io_bus.pend;
   assign io_halt_o = (run == wpil_halt);
   assign cpu_halt_o = cpu_halt;
   assign error_post_o = err_post;
   always_comb begin
      host_irq_n_o = 8'hFF;
      host_irq_n_o[level] = ~host_req;
   end
   assign wake_data_o = wake_data;
endmodule

// ### dv/wpil_top_sva.sv
// Checker for the wake-up port interrupt logic top module.
// Assumes one clock domain; bound to every wpil_top instance.
`timescale 1ns/1ps
module wpil_top_sva #(parameter int TIMEOUT_CYC = 20)
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [15:0] port_strap_i,
   input wire logic io_space_width_strap_i,
   input wire logic pfail_enable_i,
   input wire logic host_io_write_i,
   input wire logic [15:0] host_io_addr_i,
   input wire logic [7:0] host_io_data_i,
   input wire logic [2:0] host_level_i,
   input wire logic ecc_error_i,
   input wire logic bus_req_i,
   input wire logic bus_grant_i,
   input wire logic power_fail_i,
   input wire logic wake_ack_i,
   input wire logic psel,
   input wire logic pwrite,
   input wire logic cpu_nmi_o,
   input wire logic wake_pending_o,
   input wire logic [3:0] io_pending_o,
   input wire logic io_halt_o,
   input wire logic cpu_halt_o,
   input wire logic error_post_o,
   input wire logic [7:0] host_irq_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   ////////////////////////////////////////////////////////////
   // Ungranted wait length, counted here since it exceeds any repetition
   int unsigned wait_cnt;
   int unsigned next_wait_cnt;
   always_comb next_wait_cnt = (bus_req_i && !bus_grant_i) ? wait_cnt + 1 : 0;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) wait_cnt <= 0;
      else wait_cnt <= next_wait_cnt;
   end
   sequence s_hit;
      host_io_write_i && (io_space_width_strap_i ? host_io_addr_i == port_strap_i
         : host_io_addr_i[7:0] == port_strap_i[7:0]);
   endsequence
   sequence s_attn;
      s_hit ##0 (host_io_data_i == 8'h00);
   endsequence
   ////////////////////////////////////////////////////////////
   AST_WAKE: assert property (s_hit |-> ##[1:2] wake_pending_o)
      else $error("port write lost");
   AST_HOLD: assert property (wake_pending_o && !wake_ack_i |=> wake_pending_o)
      else $error("wake request dropped");
   AST_ATTN: assert property (s_attn |-> ##[1:2] cpu_nmi_o)
      else $error("no attention nmi");
   AST_HALT: assert property (io_halt_o && !host_io_write_i && !(psel && pwrite)
      |=> io_halt_o) else $error("halt left alone");
   AST_PFAIL: assert property (pfail_enable_i && $rose(power_fail_i)
      |=> cpu_nmi_o && io_halt_o && cpu_halt_o) else $error("power fail missed");
   AST_PFOFF: assert property (!pfail_enable_i && $rose(power_fail_i)
      && !cpu_halt_o && !host_io_write_i |=> !cpu_halt_o) else $error("power fail ungated");
   AST_TMO: assert property (wait_cnt == TIMEOUT_CYC
      |-> ##[0:2] (error_post_o && io_halt_o)) else $error("no bus timeout");
   AST_LEVEL: assert property (host_irq_n_o != 8'hFF
      |-> host_irq_n_o == ~(8'h01 << host_level_i)) else $error("wrong host level");
   AST_ECC: assert property (ecc_error_i |-> ##[1:2] io_pending_o[3])
      else $error("ecc request lost");
endmodule

bind wpil_top wpil_top_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) wpil_top_sva_inst (.*);

// ### dv/wpil_host_model.sv
// Host processor model: byte writes to the wake-up port.
// Assumes a one-cycle strobe is all the port needs.
`timescale 1ns/1ps
module wpil_host_model (
   input wire logic clk_i,
   output logic host_io_write_o,
   output logic [15:0] host_io_addr_o,
   output logic [7:0] host_io_data_o
);
   initial begin
      host_io_write_o = 1'b0;
      host_io_addr_o = 16'hFFFF;
      host_io_data_o = 8'hFF;
   end
   // Lines inverted after the cycle so stale values never match
   task automatic port_write(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      host_io_write_o <= 1'b1;
      host_io_addr_o <= a;
      host_io_data_o <= d;
      @(posedge clk_i);
      host_io_write_o <= 1'b0;
      host_io_addr_o <= ~a;
      host_io_data_o <= ~d;
   endtask
endmodule

// ### dv/tb_wakeup_port_interrupt_logic.sv
// Self-checking bench for the wake-up port interrupt logic.
// Assumes package, checker and host model compiled before it.
`timescale 1ns/1ps
`include "wpil_params.svh"
module tb_wakeup_port_interrupt_logic import wpil_pkg::*;;
   localparam int TMO = 20;
   logic clk_i, reset_n_i = 1'b0, io_space_width_strap_i = 1'b1, pfail_enable_i = 1'b0;
   logic timer_irq_i = 1'b0, dma_irq_i = 1'b0, error_nmi_i = 1'b0, ecc_error_i = 1'b0;
   logic bus_req_i = 1'b0, bus_grant_i = 1'b0, power_fail_i = 1'b0, wake_ack_i = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, host_io_write_i, pready, pslverr;
   logic cpu_irq_o, cpu_nmi_o, wake_pending_o, io_halt_o, cpu_halt_o, error_post_o;
   logic [15:0] port_strap_i = `WPIL_PORT_DEFAULT, host_io_addr_i;
   logic [2:0] host_level_i = 3'h5, periph_irq_i = 3'h0;
   logic [3:0] io_ack_i = 4'h0, io_pending_o, v;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [7:0] host_io_data_i, host_irq_n_o, wake_data_o, d;
   logic [32:0] exp_q[$];
   int fails = 0, compares = 0;
   wpil_host_model wpil_host_model_inst (.clk_i(clk_i), .host_io_write_o(host_io_write_i),
      .host_io_addr_o(host_io_addr_i), .host_io_data_o(host_io_data_i));
   wpil_top #(.TIMEOUT_CYC(TMO)) wpil_top_inst (.*);
   ////////////////////////////////////////////////////////////
   task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] s);
      compares++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic clear_all();
      @(posedge clk_i);
      wake_ack_i <= 1'b1;
      io_ack_i <= 4'hF;
      @(posedge clk_i);
      wake_ack_i <= 1'b0;
      io_ack_i <= 4'h0;
      apb(1'b1, `WPIL_APB_STATUS, 32'hFF);
   endtask
   task automatic wrap_up();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Read data is judged where it is valid, at the access edge
   always @(posedge clk_i) begin
      if (psel && penable && pready && !pwrite) cmp("prdata", exp_q.pop_front(), {pslverr, prdata});
   end
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      fails++;
      wrap_up();
   end
   initial begin
      logic [15:0] addrs [4];
      addrs = '{16'h0100, 16'h7700, 16'h0101, 16'h7700};
      void'($urandom(26));
      repeat (12) @(posedge clk_i);
      reset_n_i <= 1'b1;
      rd(`WPIL_APB_STATUS, 33'h0);
      rd(12'h020, 33'h100000000);
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom_range(255, 1));
         @(posedge clk_i);
         io_space_width_strap_i <= ~i[1];
         wpil_host_model_inst.port_write(addrs[i], d);
         repeat (2) @(negedge clk_i);
         cmp("wake", 33'(i[0] == i[1]), 33'(wake_pending_o));
         if (i[0] == i[1]) begin
            rd(`WPIL_APB_IOSTAT, 33'({d, 4'h0}));
            for (int m = 0; m < 3; m++) begin
               apb(1'b1, m == 2 ? `WPIL_APB_STATUS : `WPIL_APB_MASK, m == 0 ? 32'hFE : 32'hFF);
               repeat (2) @(negedge clk_i);
               cmp("irq", 33'(m == 1), 33'(cpu_irq_o));
            end
            cmp("wake", 33'h1, 33'(wake_pending_o));
            clear_all();
            @(negedge clk_i);
            cmp("wake", 33'h0, 33'(wake_pending_o));
         end
      end
      wpil_host_model_inst.port_write(16'h0100, 8'h00);
      rd(`WPIL_APB_CTRL, 33'h1);
      wpil_host_model_inst.port_write(16'h0100, 8'h5A);
      repeat (2) @(posedge clk_i);
      rd(`WPIL_APB_CTRL, 33'h0);
      clear_all();
      bus_req_i <= 1'b1;
      repeat (TMO - 2) @(negedge clk_i);
      cmp("halt", 33'h0, 33'(io_halt_o));
      repeat (5) @(negedge clk_i);
      cmp("post", 33'h3, 33'({error_post_o, io_halt_o}));
      @(posedge clk_i);
      bus_req_i <= 1'b0;
      apb(1'b1, `WPIL_APB_CTRL, 32'h1);
      rd(`WPIL_APB_CTRL, 33'h0);
      for (int e = 0; e < 2; e++) begin
         @(posedge clk_i);
         pfail_enable_i <= e[0];
         power_fail_i <= 1'b1;
         repeat (3) @(negedge clk_i);
         cmp("halts", 33'({2{e[0]}}), 33'({cpu_halt_o, io_halt_o}));
         @(posedge clk_i);
         power_fail_i <= 1'b0;
      end
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      apb(1'b1, `WPIL_APB_CTRL, 32'h2);
      @(negedge clk_i);
      cmp("host_irq", 33'hDF, 33'(host_irq_n_o));
      v = 4'($urandom_range(15, 1));
      @(posedge clk_i);
      {ecc_error_i, periph_irq_i, timer_irq_i, dma_irq_i} <= {v, 2'h3};
      @(posedge clk_i);
      {ecc_error_i, periph_irq_i, timer_irq_i, dma_irq_i} <= 6'h00;
      repeat (2) @(negedge clk_i);
      cmp("io_pend", 33'(v), 33'(io_pending_o));
      rd(`WPIL_APB_STATUS, 33'h0E);
      clear_all();
      @(negedge clk_i);
      cmp("io_pend", 33'h0, 33'(io_pending_o));
      wrap_up();
   end
endmodule
